// ==== ssp_pkg.sv ====
// shared constants, types and helpers of the serial port slave and its master
package ssp_pkg;
    // ========================================================
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_CNT = 5'h10;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
    localparam int CMD_HI = 15;
    localparam int CMD_LO = 10;
    localparam int CMD_W = 6;
    localparam logic [CMD_W-1:0] CMD_MODE = 6'h01;
    localparam logic [CMD_W-1:0] CMD_GAIN = 6'h02;
    localparam logic [CMD_W-1:0] CMD_SPARE = 6'h03;
    localparam logic [CMD_W-1:0] CMD_DIAG1 = 6'h08;
    localparam logic [CMD_W-1:0] CMD_DIAG2 = 6'h10;
    localparam logic [CMD_W-1:0] CMD_DIAG3 = 6'h18;
    localparam int BIT_HOLD = 7;
    localparam int BIT_SHORT = 6;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 6;
    localparam int BIT_FRAME_ERR = 7;
    localparam int DIAG_W = 8;
    // ========================================================
    // response headers and reset values
    localparam logic [15:0] RESP_IDLE = 16'h0200;
    localparam logic [15:0] RESP_MODE = 16'h0400;
    localparam logic [15:0] RESP_SPARE = 16'h0600;
    localparam logic [15:0] RESP_DIAG1 = 16'h1000;
    localparam logic [15:0] RESP_DIAG2 = 16'h2000;
    localparam logic [15:0] RESP_DIAG3 = 16'h3000;
    localparam logic [CMD_W-1:0] RST_LAST_CMD = 6'h00;
    localparam logic [1:0] RST_GAIN = 2'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [DIAG_W-1:0] RST_DIAG = 8'h00;
    // ========================================================
    // buffering
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    // ========================================================
    // timing
    localparam int CLK_KHZ = 25000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCK_MAX_KHZ = 4000;
    localparam int SCK_HALF_CYC = (CLK_KHZ + 2 * SCK_MAX_KHZ - 1) / (2 * SCK_MAX_KHZ);
    localparam int HALF_W = 4;
    localparam logic [HALF_W-1:0] HALF_RELOAD = HALF_W'(SCK_HALF_CYC - 1);
    localparam int GAP_NS = 1000;
    localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_RELOAD = GAP_W'(GAP_CYC - 1);
    localparam int MON_TIMEOUT_NS = 1000;
    localparam int MON_TIMEOUT_CYC = MON_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int MON_W = 8;
    localparam logic [MON_W-1:0] MON_LIMIT = MON_W'(MON_TIMEOUT_CYC);
    // ========================================================
    // master sequencer states
    typedef enum logic [5:0] {
        SSP_H_IDLE = 6'b000001,
        SSP_H_LEAD = 6'b000010,
        SSP_H_LOW = 6'b000100,
        SSP_H_HIGH = 6'b001000,
        SSP_H_TRAIL = 6'b010000,
        SSP_H_GAP = 6'b100000
    } ssp_host_state_e;
    // ========================================================
    function automatic logic [CMD_W-1:0] ssp_cmd_of(input logic [FRAME_BITS-1:0] w);
        ssp_cmd_of = w[CMD_HI:CMD_LO];
    endfunction
endpackage

// ==== ssp_if.sv ====
// serial link between the master and the slave port
`timescale 1ns/1ns
interface ssp_if;
    logic cs_n;
    logic sck;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_wire;
    // undriven line reads high, as through a pull-up
    assign sdo_wire = sdo_oe ? sdo : 1'b1;
    modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
    modport host (output cs_n, output sck, output sdi, input sdo_wire);
endinterface

// ==== ssp_device.sv ====
// slave end: frame receiver, response shifter, word FIFO and clock supervisor
`timescale 1ns/1ns
module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ssp_fifo

module ssp_device
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ssp_if.device link,
    input wire logic monitor_oscillator,
    input wire logic [DIAG_W-1:0] diag_in,
    output logic [FRAME_BITS-1:0] cmd_word,
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic overflow,
    output logic hold_mode,
    output logic short_mode,
    output logic [1:0] amp_gain,
    output logic frame_error_flag,
    output logic [DIAG_W-1:0] diag_flags,
    output logic clock_fail
);
    // ========================================================
    // synchronisers
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] mon_sync_reg;
    logic cs_d_reg;
    logic sck_d_reg;
    logic mon_d_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_sync_reg <= 2'h3;
            sck_sync_reg <= 2'h3;
            sdi_sync_reg <= 2'h3;
            mon_sync_reg <= 2'h0;
            cs_d_reg <= 1'b1;
            sck_d_reg <= 1'b1;
            mon_d_reg <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
            sck_sync_reg <= {sck_sync_reg[0], link.sck};
            sdi_sync_reg <= {sdi_sync_reg[0], link.sdi};
            mon_sync_reg <= {mon_sync_reg[0], monitor_oscillator};
            cs_d_reg <= cs_sync_reg[1];
            sck_d_reg <= sck_sync_reg[1];
            mon_d_reg <= mon_sync_reg[1];
        end
    end
    logic cs_s;
    logic sck_s;
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    logic sck_rise;
    assign cs_s = cs_sync_reg[1];
    assign sck_s = sck_sync_reg[1];
    assign cs_fall = cs_d_reg && !cs_s;
    assign cs_rise = !cs_d_reg && cs_s;
    // clock edges count only inside a frame
    assign sck_fall = !cs_s && sck_d_reg && !sck_s;
    assign sck_rise = !cs_s && !sck_d_reg && sck_s;
    // ========================================================
    // receive shifter
    logic [FRAME_BITS-1:0] rx_reg;
    logic [CNT_W-1:0] bits_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_reg <= RST_WORD;
            bits_reg <= '0;
        end else if (cs_fall) begin
            bits_reg <= '0;
        end else if (sck_rise) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], sdi_sync_reg[1]};
            // saturates so an overlong frame never wraps to sixteen
            if (bits_reg != CNT_MAX) begin
                bits_reg <= bits_reg + 1'b1;
            end
        end
    end
    logic [CMD_W-1:0] rx_cmd;
    logic key_ok;
    logic frame_ok;
    assign rx_cmd = ssp_cmd_of(rx_reg);
    assign key_ok = (rx_cmd == CMD_MODE) || (rx_cmd == CMD_GAIN) || (rx_cmd == CMD_SPARE)
        || (rx_cmd == CMD_DIAG1) || (rx_cmd == CMD_DIAG2) || (rx_cmd == CMD_DIAG3);
    assign frame_ok = (bits_reg == FRAME_CNT) && key_ok;
    // ========================================================
    // commit and configuration
    logic commit;
    logic fifo_in_ready;
    logic [CMD_W-1:0] last_cmd_reg;
    assign commit = cs_rise && frame_ok;
    always_ff @(posedge clk) begin
        if (rst) begin
            last_cmd_reg <= RST_LAST_CMD;
            hold_mode <= 1'b0;
            short_mode <= 1'b0;
            amp_gain <= RST_GAIN;
        end else if (commit) begin
            last_cmd_reg <= rx_cmd;
            if (rx_cmd == CMD_MODE) begin
                hold_mode <= rx_reg[BIT_HOLD];
                short_mode <= rx_reg[BIT_SHORT];
            end
            if (rx_cmd == CMD_GAIN) begin
                amp_gain <= rx_reg[GAIN_HI:GAIN_LO];
            end
        end
    end
    // words lost for want of room are reported, the master cannot be stalled
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= commit && !fifo_in_ready;
        end
    end
    // ========================================================
    // response shifter and output enable
    logic [FRAME_BITS-1:0] tx_reg;
    logic [FRAME_BITS-1:0] resp_next;
    logic rd_diag1;
    logic rd_diag2;
    always_comb begin
        resp_next = RESP_IDLE;
        case (last_cmd_reg)
            CMD_MODE, CMD_GAIN: resp_next = RESP_MODE;
            CMD_SPARE: resp_next = RESP_SPARE;
            CMD_DIAG1: resp_next = RESP_DIAG1 | {8'h00, diag_flags};
            CMD_DIAG2: resp_next = RESP_DIAG2 | (16'(frame_error_flag) << BIT_FRAME_ERR);
            CMD_DIAG3: resp_next = RESP_DIAG3;
            default: resp_next = RESP_IDLE;
        endcase
    end
    assign rd_diag1 = cs_fall && (last_cmd_reg == CMD_DIAG1);
    assign rd_diag2 = cs_fall && (last_cmd_reg == CMD_DIAG2);
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_reg <= RST_WORD;
            link.sdo <= 1'b1;
            link.sdo_oe <= 1'b0;
        end else if (cs_fall) begin
            tx_reg <= resp_next;
            link.sdo <= resp_next[FRAME_BITS-1];
            link.sdo_oe <= 1'b1;
        end else if (cs_s) begin
            link.sdo_oe <= 1'b0;
        end else if (sck_fall) begin
            link.sdo <= tx_reg[FRAME_BITS-1];
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
    end
    // ========================================================
    // sticky flags, set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            diag_flags <= RST_DIAG;
            frame_error_flag <= 1'b0;
        end else begin
            diag_flags <= (rd_diag1 ? RST_DIAG : diag_flags) | diag_in;
            frame_error_flag <= (rd_diag2 ? 1'b0 : frame_error_flag) || (cs_rise && !frame_ok);
        end
    end
    // ========================================================
    // main clock supervision by the monitor oscillator
    logic [MON_W-1:0] mon_cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            mon_cnt_reg <= '0;
            clock_fail <= 1'b0;
        end else if (mon_d_reg != mon_sync_reg[1]) begin
            mon_cnt_reg <= '0;
            clock_fail <= 1'b0;
        end else if (mon_cnt_reg != MON_LIMIT) begin
            mon_cnt_reg <= mon_cnt_reg + 1'b1;
        end else begin
            clock_fail <= 1'b1;
        end
    end
    // ========================================================
    // word stream toward the core, registered output stage
    logic fifo_out_valid;
    logic [FRAME_BITS-1:0] fifo_out_data;
    logic stage_load;
    assign stage_load = !cmd_valid || cmd_ready;
    ssp_fifo #(
        .WIDTH(FRAME_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(commit),
        .in_ready(fifo_in_ready),
        .in_data(rx_reg),
        .out_valid(fifo_out_valid),
        .out_ready(stage_load),
        .out_data(fifo_out_data)
    );
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_word <= RST_WORD;
        end else if (stage_load) begin
            cmd_valid <= fifo_out_valid;
            cmd_word <= fifo_out_data;
        end
    end
endmodule // ssp_device

// ==== ssp_host.sv ====
// master end: drives select and serial clock, shifts one word each way
`timescale 1ns/1ns
module ssp_host
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    ssp_if.host link,
    input wire logic req_valid,
    input wire logic [FRAME_BITS-1:0] req_word,
    output logic req_ready,
    output logic resp_valid,
    output logic [FRAME_BITS-1:0] resp_word
);
    // ========================================================
    logic [1:0] sdo_sync_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            sdo_sync_reg <= 2'h3;
        end else begin
            sdo_sync_reg <= {sdo_sync_reg[0], link.sdo_wire};
        end
    end
    // ========================================================
    // sequencer
    ssp_host_state_e state_reg;
    logic [HALF_W-1:0] half_reg;
    logic [GAP_W-1:0] gap_reg;
    logic [CNT_W-1:0] bits_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic tick;
    // half period from divider keeps sck at or below the limit
    assign tick = (half_reg == '0);
    always_ff @(posedge clk) begin
        if (rst || tick || state_reg == SSP_H_IDLE) begin
            half_reg <= HALF_RELOAD;
        end else begin
            half_reg <= half_reg - 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SSP_H_IDLE;
            link.cs_n <= 1'b1;
            link.sck <= 1'b1;
            link.sdi <= 1'b1;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_word <= RST_WORD;
            tx_reg <= RST_WORD;
            rx_reg <= RST_WORD;
            bits_reg <= '0;
            gap_reg <= '0;
        end else begin
            resp_valid <= 1'b0;
            case (state_reg)
                SSP_H_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        link.cs_n <= 1'b0;
                        tx_reg <= req_word;
                        bits_reg <= '0;
                        state_reg <= SSP_H_LEAD;
                    end
                end
                SSP_H_LEAD, SSP_H_HIGH: begin
                    if (tick) begin
                        if (state_reg == SSP_H_HIGH) begin
                            rx_reg <= {rx_reg[FRAME_BITS-2:0], sdo_sync_reg[1]};
                        end
                        if (bits_reg == FRAME_CNT) begin
                            state_reg <= SSP_H_TRAIL;
                        end else begin
                            link.sck <= 1'b0;
                            link.sdi <= tx_reg[FRAME_BITS-1];
                            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
                            state_reg <= SSP_H_LOW;
                        end
                    end
                end
                SSP_H_LOW: begin
                    if (tick) begin
                        link.sck <= 1'b1;
                        bits_reg <= bits_reg + 1'b1;
                        state_reg <= SSP_H_HIGH;
                    end
                end
                SSP_H_TRAIL: begin
                    if (tick) begin
                        link.cs_n <= 1'b1;
                        link.sdi <= 1'b1;
                        resp_valid <= 1'b1;
                        resp_word <= rx_reg;
                        gap_reg <= GAP_RELOAD;
                        state_reg <= SSP_H_GAP;
                    end
                end
                SSP_H_GAP: begin
                    if (gap_reg == '0) begin
                        state_reg <= SSP_H_IDLE;
                    end else begin
                        gap_reg <= gap_reg - 1'b1;
                    end
                end
                default: begin
                    state_reg <= SSP_H_IDLE;
                end
            endcase
        end
    end
endmodule // ssp_host

// ==== ssp_chk.sv ====
// link-level assertions between the master end and the slave port
`timescale 1ns/1ns
module ssp_chk
    import ssp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // ========================================================
    // helper counters
    logic [4:0] pulse_reg;
    logic [7:0] gap_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst || cs_n) begin
            pulse_reg <= 5'h00;
        end else if ($rose(sck)) begin
            pulse_reg <= pulse_reg + 5'h01;
        end
    end
    // saturates so a long idle never wraps to a short gap
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_reg <= 8'hFF;
        end else if (!cs_n) begin
            gap_reg <= 8'h00;
        end else if (gap_reg != 8'hFF) begin
            gap_reg <= gap_reg + 8'h01;
        end
    end
    // ========================================================
    // assertions
    oe_start_a: assert property (
        $fell(cs_n) |-> !sdo_oe ##1 !sdo_oe ##[1:3] sdo_oe)
        else $error("output not enabled after select fall");
    oe_release_a: assert property (
        $rose(cs_n) |-> ##[1:4] !sdo_oe)
        else $error("output not released after select rise");
    oe_quiet_a: assert property (
        cs_n [*6] |-> !sdo_oe)
        else $error("output driven while deselected");
    sck_idle_a: assert property (
        cs_n |-> sck)
        else $error("serial clock low while deselected");
    sck_low_a: assert property (
        $fell(sck) |-> (!sck) [*4] ##1 sck)
        else $error("serial clock low phase wrong");
    sck_high_a: assert property (
        $rose(sck) |-> sck [*4])
        else $error("serial clock high phase too short");
    pulse_count_a: assert property (
        $rose(cs_n) |-> pulse_reg == FRAME_CNT)
        else $error("frame without sixteen clock pulses");
    gap_min_a: assert property (
        $fell(cs_n) |-> gap_reg >= 8'(GAP_CYC))
        else $error("interframe gap too short");
    sdi_stable_a: assert property (
        (!cs_n && sck && $past(sck)) |-> $stable(sdi))
        else $error("input data moved while clock high");
    sdo_stable_a: assert property (
        (sck && $past(sck) && sdo_oe && $past(sdo_oe)) |-> $stable(sdo))
        else $error("output data moved while clock high");
endmodule // ssp_chk

// ==== tb_top.sv ====
// testbench: master and slave joined, plus a slave driven by a rule-breaking bench driver
`timescale 1ns/1ns
module tb_top
    import ssp_pkg::*;
    ;
    // ========================================================
    // signals and instances
    logic clk, rst, mon, mon_run, req_valid, req_ready, resp_valid, cmd_ready, cmd_valid;
    logic overflow, hold_mode, short_mode, frame_error_flag, clock_fail, sck_prev, ov_seen;
    logic cmd_valid_2, hold_mode_2, ferr_2;
    logic [15:0] req_word, resp_word, cmd_word, wire_rx, got;
    logic [7:0] diag_in, diag_flags;
    logic [1:0] amp_gain;
    int err_count;
    int comparisons;
    localparam logic [15:0] TX [11] = '{16'h04C0, 16'h0880, 16'hFC00, 16'h4000, 16'h2000,
        16'h0C00, 16'h6000, 16'h0400, 16'h0840, 16'h0440, 16'h08C0};
    localparam logic [15:0] RX [11] = '{RESP_IDLE, RESP_MODE, RESP_MODE, RESP_MODE,
        RESP_DIAG2 | 16'h0080, RESP_DIAG1 | 16'h005A, RESP_SPARE, RESP_DIAG3, RESP_MODE,
        RESP_MODE, RESP_MODE};
    ssp_if i_ssp_if();
    ssp_if i_ssp_if_2();
    ssp_host i_ssp_host (.clk(clk), .rst(rst), .link(i_ssp_if.host), .req_valid(req_valid),
        .req_word(req_word), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_word(resp_word));
    ssp_device i_ssp_device (.clk(clk), .rst(rst), .link(i_ssp_if.device),
        .monitor_oscillator(mon), .diag_in(diag_in), .cmd_word(cmd_word),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .overflow(overflow),
        .hold_mode(hold_mode), .short_mode(short_mode), .amp_gain(amp_gain),
        .frame_error_flag(frame_error_flag), .diag_flags(diag_flags), .clock_fail(clock_fail));
    ssp_device i_ssp_device_2 (.clk(clk), .rst(rst), .link(i_ssp_if_2.device),
        .monitor_oscillator(mon), .diag_in(8'h00), .cmd_word(), .cmd_valid(cmd_valid_2),
        .cmd_ready(1'b0), .overflow(), .hold_mode(hold_mode_2), .short_mode(), .amp_gain(),
        .frame_error_flag(ferr_2), .diag_flags(), .clock_fail());
    ssp_chk i_ssp_chk (.clk(clk), .rst(rst), .cs_n(i_ssp_if.cs_n), .sck(i_ssp_if.sck),
        .sdi(i_ssp_if.sdi), .sdo(i_ssp_if.sdo), .sdo_oe(i_ssp_if.sdo_oe));
    // ========================================================
    // clocks and wire monitor
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // free-running supervising clock, gated only to provoke a clock failure
    initial begin
        mon = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (mon_run) begin
                mon = ~mon;
            end
        end
    end
    always @(posedge clk) begin
        sck_prev <= i_ssp_if.sck;
        if (!i_ssp_if.cs_n && i_ssp_if.sck && !sck_prev) begin
            wire_rx <= {wire_rx[14:0], i_ssp_if.sdi};
        end
        if (overflow === 1'b1) begin
            ov_seen <= 1'b1;
        end
    end
    // ========================================================
    // tasks
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic host_xfer(input logic [15:0] word, input logic [15:0] exp);
        int i;
        i = 0;
        while (req_ready !== 1'b1 && i < 400) begin
            tick(1);
            i++;
        end
        if (i >= 400) begin
            err_count++;
        end
        req_word = word;
        req_valid = 1'b1;
        tick(1);
        req_valid = 1'b0;
        i = 0;
        while (resp_valid !== 1'b1 && i < 400) begin
            tick(1);
            i++;
        end
        if (i >= 400) begin
            err_count++;
        end
        check("resp_word", resp_word, exp);
        check("wire_rx", wire_rx, word);
    endtask
    // bench-made link clock: 4 cycles per half, 320 ns per pulse
    task automatic bang(input logic [15:0] word, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        i_ssp_if_2.cs_n = 1'b0;
        tick(4);
        for (int b = 0; b < n; b++) begin
            i_ssp_if_2.sck = 1'b0;
            i_ssp_if_2.sdi = word[15-b];
            tick(4);
            rx = {rx[14:0], i_ssp_if_2.sdo_wire};
            i_ssp_if_2.sck = 1'b1;
            tick(4);
        end
        i_ssp_if_2.cs_n = 1'b1;
        i_ssp_if_2.sdi = 1'b1;
        tick(30);
    endtask
    task automatic pop(input logic [15:0] exp);
        int i;
        i = 0;
        while (cmd_valid !== 1'b1 && i < 50) begin
            tick(1);
            i++;
        end
        if (i >= 50) begin
            err_count++;
        end
        check("cmd_word", cmd_word, exp);
        cmd_ready = 1'b1;
        tick(1);
        cmd_ready = 1'b0;
        tick(2);
    endtask
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ========================================================
    // watchdog and main sequence
    initial begin
        #400000;
        err_count++;
        close_out();
    end
    initial begin
        {rst, mon_run, i_ssp_if_2.cs_n, i_ssp_if_2.sck, i_ssp_if_2.sdi, sck_prev} = 6'h3F;
        {req_valid, cmd_ready, ov_seen} = 3'h0;
        req_word = 16'h0000;
        wire_rx = 16'h0000;
        diag_in = 8'h00;
        err_count = 0;
        comparisons = 0;
        tick(16);
        rst = 1'b0;
        tick(3);
        // FIFO left undrained so the last frame overflows
        for (int k = 0; k < 11; k++) begin
            if (k == 4) begin
                diag_in = 8'h5A;
                tick(1);
                diag_in = 8'h00;
            end
            host_xfer(TX[k], RX[k]);
            // slave commits only after it sees select rise through its synchronisers
            tick(5);
            case (k)
                0: check("modes", 16'({hold_mode, short_mode}), 16'h0003);
                1: check("amp_gain", 16'(amp_gain), 16'h0002);
                2: check("frame_err", 16'(frame_error_flag), 16'h0001);
                4: check("err_diag", {7'h00, frame_error_flag, diag_flags}, 16'h005A);
                5: check("diag_flags", 16'(diag_flags), 16'h0000);
                7: check("modes", 16'({hold_mode, short_mode}), 16'h0000);
                10: check("gain_ovf", 16'({amp_gain, ov_seen}), 16'h0007);
                default: ;
            endcase
        end
        for (int k = 0; k < 11; k++) begin
            if (k != 2 && k != 10) begin
                pop(TX[k]);
            end
        end
        tick(5);
        check("cmd_valid", 16'(cmd_valid), 16'h0000);
        repeat (4) begin
            i_ssp_if_2.sck = 1'b0;
            tick(4);
            i_ssp_if_2.sck = 1'b1;
            tick(4);
        end
        check("idle_2", 16'({i_ssp_if_2.sdo_oe, ferr_2, cmd_valid_2}), 16'h0000);
        bang(16'h04C0, 15, got);
        check("short_rx", got, RESP_IDLE >> 1);
        check("short_2", 16'({ferr_2, cmd_valid_2, hold_mode_2}), 16'h0004);
        bang(16'h04C0, 16, got);
        check("full_rx", got, RESP_IDLE);
        check("full_2", 16'({cmd_valid_2, hold_mode_2}), 16'h0003);
        mon_run = 1'b0;
        #2000;
        tick(1);
        check("clock_fail", 16'(clock_fail), 16'h0001);
        mon_run = 1'b1;
        #400;
        tick(1);
        check("clock_ok", 16'(clock_fail), 16'h0000);
        close_out();
    end
endmodule // tb_top
